//--- dv/adcmc_host.sv
`timescale 1ns/100ps
module adcmc_host (
  input  wire logic        clk_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic        wb_ack_i,
  input  wire logic        wb_err_i,
  output logic             wb_cyc_o,
  output logic             wb_stb_o,
  output logic             wb_we_o,
  output logic [7:0]       wb_adr_o,
  output logic [3:0]       wb_sel_o,
  output logic [31:0]      wb_dat_o
);
  initial
  begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o = 1'b0;
    wb_adr_o = 8'h00;
    wb_sel_o = 4'h3;
    wb_dat_o = 32'h0;
  end
  // one classic cycle, entered just after a clock edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e, output logic hung);
    int n;
    n = 0;
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= w;
    wb_adr_o <= a;
    wb_dat_o <= w ? d : ~wb_dat_o;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (!(wb_ack_i || wb_err_i) && n < 64);
    q = wb_dat_i;
    e = wb_err_i;
    hung = !(wb_ack_i || wb_err_i);
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_dat_o <= ~wb_dat_o;
    @(posedge clk_i);
  endtask
endmodule

//--- dv/adcmc_regs_bench.sv
`timescale 1ns/100ps
module adcmc_regs_bench;
  logic        clk_sys_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc, stb, we, ack, err, pin, oe, crc, rxc, ansi, tmo, irq, e, h;
  logic [7:0]  adr;
  logic [3:0]  sel, done, rdd, en;
  logic [31:0] wd, rdat, q;
  logic [1:0]  ws, power_level_select;
  logic [14:0] oversampling_ratio_select;
  int          error_cnt = 0, checks = 0, seed = 29988, md, ck, fl, ist, msk;
  always #12.5 clk_sys_i = ~clk_sys_i;
  adcmc_host u_adcmc_host (.clk_i(clk_sys_i), .wb_dat_i(rdat), .wb_ack_i(ack), .wb_err_i(err),
    .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wd));
  adcmc_regs u_adcmc_regs (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wb_err_o(err), .conv_done_i(done), .result_read_i(rdd), .result_ready_pin_o(pin),
    .result_ready_pin_oe_o(oe), .reg_crc_en_o(crc), .rx_crc_en_o(rxc), .crc_ansi_o(ansi),
    .word_size_select_o(ws), .timeout_en_o(tmo), .chan_convert_enable_o(en),
    .oversampling_ratio_o(oversampling_ratio_select), .power_level_select_o(power_level_select), .irq_o(irq));
  task tally_and_finish;
    if (error_cnt == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, g);
    end
  endtask
  task bus(input logic w, input int i, input int v);
    u_adcmc_host.xfer(w, 8'(i * 4), 32'(v), q, e, h);
    if (h)
    begin
      error_cnt++;
      tally_and_finish();
    end
  endtask
  task rd(input int i, input int x);
    bus(1'b0, i, 0);
    chk("reg", x, q);
  endtask
  task wm(input int v);
    bus(1'b1, 2, v);
    ist = ist | (md[10] && !v[10] ? 16 : 0);
    md = v & (md | 16'hFBFF);
  endtask
  task outs;
    int r;
    r = ck[5] ? 32'h40 : (ck[4:2] == 7 ? 32'h3F80 : 32'h80 << ck[4:2]);
    repeat (2) @(posedge clk_sys_i);
    chk("clk", {ck[11:8], ck[1:0], r[14:0]}, {en, power_level_select, oversampling_ratio_select});
    chk("mode", {md[13:11], md[9:8], md[4]}, {crc, rxc, ansi, ws, tmo});
  endtask
  function automatic logic src();
    return md[3:2] == 0 ? (fl & ck[11:8]) == ck[11:8] : (fl & ck[11:8]) != 0;
  endfunction
  task ev(input logic [3:0] dn, input logic [3:0] r);
    logic lo, was;
    int   nlo;
    was = src();
    nlo = 0;
    done <= dn;
    rdd <= r;
    @(posedge clk_sys_i);
    done <= 4'h0;
    rdd <= 4'h0;
    fl = (fl & ~r) | (dn & ck[11:8]);
    ist = ist | (dn & ck[11:8]);
    repeat (8)
    begin
      @(posedge clk_sys_i);
      nlo += !pin;
    end
    lo = !md[0] && src();
    chk("pin", {lo | !md[1], !lo}, {oe, pin});
    chk("irq", (ist & msk) != 0, irq);
    if (md[0])
      chk("pulse", (src() && !was) ? adcmc_pkg::PULSE_CYC : 0, nlo);
  endtask
  initial
  begin
    done = 4'h0;
    rdd = 4'h0;
    md = 16'h0510;
    ck = 16'h0F0E;
    fl = 0;
    ist = 0;
    repeat (8) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    outs();
    rd(2, md);
    rd(3, ck);
    rd(1, 16'h0500);
    rd(8, 0);
    bus(1'b1, 9, 31);
    msk = 31;
    for (int i = 0; i < 6; i++)
    begin
      wm($random(seed) & 16'h3F1F);
      rd(2, md);
      outs();
    end
    for (int i = 0; i < 16; i++)
    begin
      ck = $random(seed) & 16'h0F03 | i << 2;
      bus(1'b1, 3, ck);
      rd(3, ck);
      outs();
    end
    bus(1'b1, 3, 16'hFF0E);
    ck = 16'h0F0E;
    rd(3, ck);
    wm(16'h0004);
    rd(8, ist);
    ev(4'h1, 4'h0);
    rd(1, md & 16'h3F00 | fl);
    bus(1'b1, 8, ist);
    ist = 0;
    rd(8, ist);
    bus(1'b1, 9, 0);
    msk = 0;
    ev(4'h2, 4'h0);
    ev(4'h0, 4'h3);
    wm(16'h0000);
    ev(4'h7, 4'h0);
    ev(4'h8, 4'h0);
    rd(1, md & 16'h3F00 | fl);
    wm(16'h0002);
    ev(4'h0, 4'hF);
    wm(16'h0005);
    ev(4'h1, 4'h0);
    bus(1'b1, 5, 16'hFFFF);
    chk("err", 1'b1, e);
    rd(5, 0);
    chk("err", 1'b1, e);
    tally_and_finish();
  end
endmodule

//--- dv/adcmc_regs_monitor.sv
`timescale 1ns/100ps
module adcmc_regs_monitor #(
  parameter int unsigned NCH = 4
) (
  input wire logic           clk_sys_i,
  input wire logic           rst_i,
  input wire logic           wb_cyc_i,
  input wire logic           wb_stb_i,
  input wire logic           wb_ack_o,
  input wire logic           wb_err_o,
  input wire logic           result_ready_pin_o,
  input wire logic           result_ready_pin_oe_o,
  input wire logic [NCH-1:0] chan_convert_enable_o,
  input wire logic [14:0]    oversampling_ratio_o,
  input wire logic [1:0]     power_level_select_o
);
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  answer_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=>
    wb_ack_o || wb_err_o)
    else $error("no answer one cycle after request");
  ack_cause_a: assert property (wb_ack_o || wb_err_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("answer without request");
  one_answer_a: assert property (!(wb_ack_o && wb_err_o))
    else $error("ack and err together");
  cfg_hold_a: assert property (!wb_cyc_i [*4] |=>
    $stable({chan_convert_enable_o, oversampling_ratio_o, power_level_select_o}))
    else $error("clock config changed without write");
  pin_drive_a: assert property (!result_ready_pin_o |-> result_ready_pin_oe_o)
    else $error("ready pin low while not driven");
  reset_vals_a: assert property ($fell(rst_i) |-> &chan_convert_enable_o &&
    oversampling_ratio_o == 15'h0400 && power_level_select_o == 2'h2)
    else $error("clock config not at reset values");
  osr_legal_a: assert property ($onehot(oversampling_ratio_o) ||
    oversampling_ratio_o == 15'h3F80)
    else $error("illegal oversampling ratio");
endmodule
bind adcmc_regs adcmc_regs_monitor #(.NCH(NCH)) u_adcmc_regs_monitor (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .result_ready_pin_o(result_ready_pin_o),
  .result_ready_pin_oe_o(result_ready_pin_oe_o),
  .chan_convert_enable_o(chan_convert_enable_o),
  .oversampling_ratio_o(oversampling_ratio_o), .power_level_select_o(power_level_select_o));

//--- src/adcmc_pkg.sv
package adcmc_pkg;
  localparam int unsigned ADDR_W = 8;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_STATUS   = 6'h01;
  localparam logic [5:0] IDX_MODE     = 6'h02;
  localparam logic [5:0] IDX_CLOCK    = 6'h03;
  localparam logic [5:0] IDX_IRQ_STAT = 6'h08;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h09;
  localparam logic [15:0] MODE_RST    = 16'h0510;
  localparam logic [15:0] CLOCK_RST   = 16'h0F0E;
  localparam logic [15:0] MODE_WMASK  = 16'h3F1F;
  localparam logic [15:0] CLOCK_WMASK = 16'h0FFF;
  localparam int unsigned M_REGCRC  = 13;
  localparam int unsigned M_RXCRC   = 12;
  localparam int unsigned M_CRCTYPE = 11;
  localparam int unsigned M_RESET   = 10;
  localparam int unsigned M_WLEN    = 8;
  localparam int unsigned M_TIMEOUT = 4;
  localparam int unsigned M_SEL     = 2;
  localparam int unsigned M_FLOAT   = 1;
  localparam int unsigned M_FMT     = 0;
  localparam int unsigned C_EN      = 8;
  localparam int unsigned C_FAST    = 5;
  localparam int unsigned C_OSR     = 2;
  localparam int unsigned C_PWR     = 0;
  // interrupt status bits: 3:0 new result per channel, 4 reset flag cleared
  localparam int unsigned IRQ_W     = 5;
  // fixed low pulse width on the ready pin
  localparam int unsigned PULSE_NS  = 100;
  localparam int unsigned CLK_NS    = 25;
  localparam int unsigned PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [14:0] OSR_64    = 15'h0040;
  localparam logic [14:0] OSR_16256 = 15'h3F80;
endpackage

//--- src/adcmc_regs.sv
// Implementation choice: register access over Wishbone.
`timescale 1ns/100ps
// Function
// - status bits 3:0 show per-channel new-result flags, reset to zero
// - mode register at index 2, reset value 0x0510
// - mode bit 13 enables register map CRC
// - mode bit 12 enables input frame CRC check
// - mode bit 11 selects CCITT or ANSI CRC polynomial
// - reset flag reads 1 after reset, cleared by writing 0
// - mode bits 9:8 choose 16, 24, 32 padded or 32 sign-extended words
// - mode bits 3:2 choose lagging, OR or leading channel for ready pin
// - idle ready pin drives high or floats per mode bit 1
// - ready pin held low or pulsed low per mode bit 0
// - clock register at index 3, reset value 0x0F0E
// - clock bits 11:8 enable channels 3 down to 0
// - clock bit 5 forces oversampling ratio 64
// - clock bits 4:2 select ratio 128 to 16256
// - clock bits 1:0 select power mode, reset 10
module adcmc_regs #(
  parameter int unsigned NCH = 4
) (
  input  wire logic                       clk_sys_i,
  input  wire logic                       rst_i,
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [adcmc_pkg::ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [31:0]                wb_dat_i,
  output logic [31:0]                     wb_dat_o,
  output logic                            wb_ack_o,
  output logic                            wb_err_o,
  input  wire logic [NCH-1:0]             conv_done_i,
  input  wire logic [NCH-1:0]             result_read_i,
  output logic                            result_ready_pin_o,
  output logic                            result_ready_pin_oe_o,
  output logic                            reg_crc_en_o,
  output logic                            rx_crc_en_o,
  output logic                            crc_ansi_o,
  output logic [1:0]                      word_size_select_o,
  output logic                            timeout_en_o,
  output logic [NCH-1:0]                  chan_convert_enable_o,
  output logic [14:0]                     oversampling_ratio_o,
  output logic [1:0]                      power_level_select_o,
  output logic                            irq_o
);
  logic [15:0]     mode;
  logic [15:0]     clock_cfg;
  logic [NCH-1:0]  new_result;
  logic [adcmc_pkg::IRQ_W-1:0] irq_stat;
  logic [adcmc_pkg::IRQ_W-1:0] irq_mask;
  logic [NCH-1:0]  prev_flags;
  logic [3:0]      pulse_cnt;
  logic            pin_low;
  logic            req;
  logic            wr;
  logic [5:0]      idx;
  logic            mapped;
  logic [15:0]     wdata;
  logic [NCH-1:0]  enabled;
  logic [NCH-1:0]  en_flags;
  logic            ready_src;
  logic            ready_src_q;
  logic            reset_clear;
  logic [14:0]     next_osr;
  logic [31:0]     next_rdata;

  assign req     = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign idx     = wb_adr_i[7:2];
  assign wr      = req && wb_we_i && mapped;
  assign wdata   = {wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00, wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00};
  assign enabled = clock_cfg[adcmc_pkg::C_EN +: NCH];
  assign en_flags = new_result & enabled;

  // address decode
  always_comb
  begin
    mapped     = 1'b1;
    next_rdata = 32'h0000_0000;
    if (idx == adcmc_pkg::IDX_STATUS)
    begin
      next_rdata[15:0] = {mode[15:8] & 8'h3F, 4'h0, 4'(new_result)};
    end
    else if (idx == adcmc_pkg::IDX_MODE)
    begin
      next_rdata[15:0] = mode;
    end
    else if (idx == adcmc_pkg::IDX_CLOCK)
    begin
      next_rdata[15:0] = clock_cfg & adcmc_pkg::CLOCK_WMASK;
    end
    else if (idx == adcmc_pkg::IDX_IRQ_STAT)
    begin
      next_rdata[adcmc_pkg::IRQ_W-1:0] = irq_stat;
    end
    else if (idx == adcmc_pkg::IDX_IRQ_MASK)
    begin
      next_rdata[adcmc_pkg::IRQ_W-1:0] = irq_mask;
    end
    else
    begin
      mapped = 1'b0;
    end
  end

  // bus answer: one cycle after the request, error for unmapped addresses
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= req && mapped;
      wb_err_o <= req && !mapped;
      wb_dat_o <= (req && mapped) ? next_rdata : 32'h0000_0000;
    end
  end

  assign reset_clear = wr && idx == adcmc_pkg::IDX_MODE && wb_sel_i[1]
                       && !wb_dat_i[8 + adcmc_pkg::M_RESET - 8] && mode[adcmc_pkg::M_RESET];

  // mode register; reset flag can only be cleared, never set by software
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mode <= adcmc_pkg::MODE_RST;
    end
    else if (wr && idx == adcmc_pkg::IDX_MODE)
    begin
      mode <= (wdata & adcmc_pkg::MODE_WMASK & ~(16'h0001 << adcmc_pkg::M_RESET))
            | (16'(mode[adcmc_pkg::M_RESET] & wdata[adcmc_pkg::M_RESET]) << adcmc_pkg::M_RESET);
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      clock_cfg <= adcmc_pkg::CLOCK_RST;
    end
    else if (wr && idx == adcmc_pkg::IDX_CLOCK)
    begin
      clock_cfg <= wdata & adcmc_pkg::CLOCK_WMASK;
    end
  end

  // new-result flags: set by conversion, cleared when the result is read; set wins
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      new_result <= '0;
    end
    else
    begin
      new_result <= (new_result & ~result_read_i) | (conv_done_i & enabled);
    end
  end

  // interrupt mask register
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      irq_mask <= '0;
    end
    else if (wr && idx == adcmc_pkg::IDX_IRQ_MASK)
    begin
      irq_mask <= wdata[adcmc_pkg::IRQ_W-1:0];
    end
  end

  // interrupt status: write one to clear, set wins
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      irq_stat <= '0;
    end
    else
    begin
      irq_stat <= (irq_stat & ~((wr && idx == adcmc_pkg::IDX_IRQ_STAT)
                   ? wdata[adcmc_pkg::IRQ_W-1:0] : '0))
                | {reset_clear, NCH'(conv_done_i & enabled)};
    end
  end

  // level interrupt, high while an unmasked status bit is set
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      irq_o <= 1'b0;
    end
    else
    begin
      irq_o <= |(irq_stat & irq_mask);
    end
  end

  // ready source selection
  always_comb
  begin
    case (mode[adcmc_pkg::M_SEL +: 2])
      2'b00:   ready_src = (en_flags == enabled) && (|enabled);
      2'b01:   ready_src = |en_flags;
      default: ready_src = |(conv_done_i & enabled) || (|en_flags);
    endcase
  end

  // ready pin: held low or fixed pulse, idle high or float
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ready_src_q <= 1'b0;
      pulse_cnt   <= 4'h0;
      pin_low     <= 1'b0;
    end
    else
    begin
      ready_src_q <= ready_src;
      if (ready_src && !ready_src_q)
      begin
        pulse_cnt <= 4'(adcmc_pkg::PULSE_CYC);
      end
      else if (pulse_cnt != 4'h0)
      begin
        pulse_cnt <= pulse_cnt - 4'h1;
      end
      if (mode[adcmc_pkg::M_FMT])
      begin
        pin_low <= (ready_src && !ready_src_q) || pulse_cnt > 4'h1;
      end
      else
      begin
        pin_low <= ready_src;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      result_ready_pin_o    <= 1'b1;
      result_ready_pin_oe_o <= 1'b1;
    end
    else
    begin
      result_ready_pin_o    <= !pin_low;
      result_ready_pin_oe_o <= pin_low || !mode[adcmc_pkg::M_FLOAT];
    end
  end

  // oversampling ratio decode
  always_comb
  begin
    if (clock_cfg[adcmc_pkg::C_FAST])
    begin
      next_osr = adcmc_pkg::OSR_64;
    end
    else if (clock_cfg[adcmc_pkg::C_OSR +: 3] == 3'h7)
    begin
      next_osr = adcmc_pkg::OSR_16256;
    end
    else
    begin
      next_osr = 15'h0080 << clock_cfg[adcmc_pkg::C_OSR +: 3];
    end
  end

  // register map crc enable
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      reg_crc_en_o <= adcmc_pkg::MODE_RST[adcmc_pkg::M_REGCRC];
    end
    else
    begin
      reg_crc_en_o <= mode[adcmc_pkg::M_REGCRC];
    end
  end

  // input frame crc enable
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rx_crc_en_o <= adcmc_pkg::MODE_RST[adcmc_pkg::M_RXCRC];
    end
    else
    begin
      rx_crc_en_o <= mode[adcmc_pkg::M_RXCRC];
    end
  end

  // crc polynomial choice
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      crc_ansi_o <= adcmc_pkg::MODE_RST[adcmc_pkg::M_CRCTYPE];
    end
    else
    begin
      crc_ansi_o <= mode[adcmc_pkg::M_CRCTYPE];
    end
  end

  // data word size
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      word_size_select_o <= adcmc_pkg::MODE_RST[adcmc_pkg::M_WLEN +: 2];
    end
    else
    begin
      word_size_select_o <= mode[adcmc_pkg::M_WLEN +: 2];
    end
  end

  // interface timeout enable
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      timeout_en_o <= adcmc_pkg::MODE_RST[adcmc_pkg::M_TIMEOUT];
    end
    else
    begin
      timeout_en_o <= mode[adcmc_pkg::M_TIMEOUT];
    end
  end

  // channel converter enables
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      chan_convert_enable_o <= adcmc_pkg::CLOCK_RST[adcmc_pkg::C_EN +: NCH];
    end
    else
    begin
      chan_convert_enable_o <= enabled;
    end
  end

  // oversampling ratio value
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      oversampling_ratio_o <= 15'h0400;
    end
    else
    begin
      oversampling_ratio_o <= next_osr;
    end
  end

  // power mode
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      power_level_select_o <= adcmc_pkg::CLOCK_RST[adcmc_pkg::C_PWR +: 2];
    end
    else
    begin
      power_level_select_o <= clock_cfg[adcmc_pkg::C_PWR +: 2];
    end
  end
endmodule
